// ---- shared/podc_defines.vh ----
// Register indices, field masks, reset values and bus codes of the port drive and over-current control block.
`ifndef PODC_DEFINES_VH
`define PODC_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define PODC_IDX_ODS_S     14'h02df
`define PODC_IDX_ODS_J     14'h031f
`define PODC_IDX_RSVD      14'h02e0
`define PODC_IDX_OCPE      14'h0310
`define PODC_IDX_OCIE      14'h0311
`define PODC_IDX_OCIF      14'h0312

// Internal register select codes.
`define PODC_SEL_NONE      3'h0
`define PODC_SEL_ODS_S     3'h1
`define PODC_SEL_ODS_J     3'h2
`define PODC_SEL_RSVD      3'h3
`define PODC_SEL_OCPE      3'h4
`define PODC_SEL_OCIE      3'h5
`define PODC_SEL_OCIF      3'h6

// Implemented bits.
`define PODC_ODS_S_MASK    8'hff
`define PODC_ODS_J_MASK    8'hff
`define PODC_OC_MASK       8'h75
`define PODC_OC_SUPPLY_BIT 2

// Reset values.
`define PODC_ODS_RESET     8'h00
`define PODC_OC_RESET      8'h00
`define PODC_RSVD_VALUE    8'h00

// Bus widths and response codes.
`define PODC_AW            16
`define PODC_RESP_OKAY     2'h0
`define PODC_RESP_DECERR   2'h3

`endif

// ---- verilog/podc_port_ctl.v ----
// Open-drain select and over-current protection control of two ports behind an AXI4-Lite slave.
//
// Notes on behaviour
// [R1] With a pin's open-drain bit set the pin is only ever driven low and its high drive stays off.
// [R2] With a pin's open-drain bit clear the pin is driven push-pull.
// [R3] A pin configured as input is never driven, whatever its open-drain bit says.
// [R4] Open-drain bits that a port does not implement read as zero.
// [R5] Both open-drain registers reset to zero and may be read and written at any time.
// [R6] The reserved register always reads 0x00 and ignores writes.
// [R7] Enable bits 6, 5, 4 and 0 switch the over-current detector of the same port pin on and off.
// [R8] Enable bit 2 switches the over-current detector of the switched supply output on and off.
// [R9] Each interrupt enable bit at 6, 5, 4, 2 and 0 enables the interrupt of its channel.
// [R10] A clear interrupt enable bit masks its channel's flag from the interrupt request.
// [R11] A channel's event flag is set whenever its detector reports over-current, and reads 1 for an event.
// [R12] Writing 1 to an event flag clears it, and the flag register may be read at any time.
// [R13] The detector enable and interrupt enable registers are read and write at any time.
// [R14] Writing 0 to a flag leaves it alone, and bits 7, 3 and 1 of the over-current registers read zero.
// [R15] One interrupt request is raised while any channel has both its flag and its enable set.
// [R16] All control registers reset to zero with detectors off, interrupts disabled and flags clear.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "podc_defines.vh"

module podc_port_ctl (
	input  wire                   clk_i,
	input  wire                   arst_n_i,
	// AXI4-Lite slave.
	input  wire [`PODC_AW-1:0]    s_axi_awaddr_i,
	input  wire                   s_axi_awvalid_i,
	output wire                   s_axi_awready_o,
	input  wire [31:0]            s_axi_wdata_i,
	input  wire [3:0]             s_axi_wstrb_i,
	input  wire                   s_axi_wvalid_i,
	output wire                   s_axi_wready_o,
	output wire [1:0]             s_axi_bresp_o,
	output wire                   s_axi_bvalid_o,
	input  wire                   s_axi_bready_i,
	input  wire [`PODC_AW-1:0]    s_axi_araddr_i,
	input  wire                   s_axi_arvalid_i,
	output wire                   s_axi_arready_o,
	output wire [31:0]            s_axi_rdata_o,
	output wire [1:0]             s_axi_rresp_o,
	output wire                   s_axi_rvalid_o,
	input  wire                   s_axi_rready_i,
	// Port S and port J pin data and direction from the port logic.
	input  wire [7:0]             port_s_data_i,
	input  wire [7:0]             port_s_dir_i,
	input  wire [7:0]             port_j_data_i,
	input  wire [7:0]             port_j_dir_i,
	// Pad drive.
	output wire [7:0]             pad_s_o,
	output wire [7:0]             pad_s_oe_o,
	output wire [7:0]             pad_j_o,
	output wire [7:0]             pad_j_oe_o,
	// Over-current detectors.
	input  wire [7:0]             oc_detect_i,
	output wire [7:0]             oc_detector_en_o,
	output wire                   oc_irq_o
);

	function [2:0] reg_sel;
		input [`PODC_AW-1:0] addr;
		begin
			case (addr[`PODC_AW-1:2])
				`PODC_IDX_ODS_S: reg_sel = `PODC_SEL_ODS_S;
				`PODC_IDX_ODS_J: reg_sel = `PODC_SEL_ODS_J;
				`PODC_IDX_RSVD:  reg_sel = `PODC_SEL_RSVD;
				`PODC_IDX_OCPE:  reg_sel = `PODC_SEL_OCPE;
				`PODC_IDX_OCIE:  reg_sel = `PODC_SEL_OCIE;
				`PODC_IDX_OCIF:  reg_sel = `PODC_SEL_OCIF;
				default:         reg_sel = `PODC_SEL_NONE;
			endcase
		end
	endfunction

	// Output enable of a pad: off for inputs, always on for push-pull outputs, low level only when open-drain.
	function [7:0] pad_enable;
		input [7:0] dir;
		input [7:0] ods;
		input [7:0] data;
		begin
			pad_enable = dir & (~ods | ~data); // [R1] [R2] [R3]
		end
	endfunction

	// Pad level: an open-drain pin never shows a high level, so the line is released rather than driven high.
	function [7:0] pad_level;
		input [7:0] ods;
		input [7:0] data;
		begin
			pad_level = data & ~ods; // [R1] [R2]
		end
	endfunction

	// Over-current registers implement bits 6, 5, 4, 2 and 0 only.
	function [7:0] oc_keep;
		input [7:0] val;
		begin
			oc_keep = val & `PODC_OC_MASK; // [R14]
		end
	endfunction

	reg  [7:0]            ods_s_q;
	reg  [7:0]            ods_j_q;
	reg  [7:0]            ocpe_q;
	reg  [7:0]            ocie_q;
	reg  [7:0]            ocif_q;
	reg  [7:0]            ocif_d;
	reg  [7:0]            oc_meta_q;
	reg  [7:0]            oc_sync_q;
	reg                   irq_q;
	reg  [7:0]            pad_s_q;
	reg  [7:0]            pad_s_oe_q;
	reg  [7:0]            pad_j_q;
	reg  [7:0]            pad_j_oe_q;

	reg                   awready_q;
	reg                   wready_q;
	reg                   aw_hold_q;
	reg                   w_hold_q;
	reg  [`PODC_AW-1:0]   aw_addr_q;
	reg  [7:0]            w_data_q;
	reg                   w_lane_q;
	reg                   bvalid_q;
	reg  [1:0]            bresp_q;
	reg                   arready_q;
	reg                   rvalid_q;
	reg  [31:0]           rdata_q;
	reg  [1:0]            rresp_q;

	reg  [7:0]            rd_byte;
	reg  [1:0]            rd_resp;
	reg  [7:0]            flag_clr;

	wire                  wr_fire;
	wire [2:0]            wr_sel;
	wire [2:0]            rd_sel;
	wire                  wr_en;
	wire [7:0]            oc_set;
	wire [7:0]            oc_pending;

	assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
	assign wr_sel  = reg_sel(aw_addr_q);
	assign rd_sel  = reg_sel(s_axi_araddr_i);
	// Only the low byte lane carries register data, so other lanes are ignored.
	assign wr_en   = wr_fire & w_lane_q;

	// Detector levels are asynchronous to the bus clock and pass two flip-flops.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oc_meta_q <= 8'h00;
			oc_sync_q <= 8'h00;
		end else begin
			oc_meta_q <= oc_detect_i;
			oc_sync_q <= oc_meta_q;
		end
	end

	// A disabled detector reports nothing, so a stray level on its input cannot set a flag.
	assign oc_set = oc_keep(oc_sync_q & ocpe_q); // [R11]

	// A channel whose interrupt enable is clear is masked out of the request.
	assign oc_pending = ocif_q & ocie_q; // [R9] [R10]

	always @* begin
		flag_clr = 8'h00;
		if (wr_en && (wr_sel == `PODC_SEL_OCIF)) begin
			flag_clr = w_data_q; // [R12] [R14]
		end
		// A detector event in the cycle of the clear keeps the flag set.
		ocif_d = oc_keep((ocif_q & ~flag_clr) | oc_set); // [R11] [R12]
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ods_s_q <= `PODC_ODS_RESET; // [R5] [R16]
			ods_j_q <= `PODC_ODS_RESET; // [R5] [R16]
			ocpe_q  <= `PODC_OC_RESET; // [R16]
			ocie_q  <= `PODC_OC_RESET; // [R16]
			ocif_q  <= `PODC_OC_RESET; // [R16]
			irq_q   <= 1'b0;
		end else begin
			ocif_q <= ocif_d;
			if (wr_en) begin
				case (wr_sel)
					`PODC_SEL_ODS_S: ods_s_q <= w_data_q & `PODC_ODS_S_MASK; // [R4] [R5]
					`PODC_SEL_ODS_J: ods_j_q <= w_data_q & `PODC_ODS_J_MASK; // [R4] [R5]
					`PODC_SEL_OCPE:  ocpe_q  <= oc_keep(w_data_q); // [R7] [R8] [R13] [R14]
					`PODC_SEL_OCIE:  ocie_q  <= oc_keep(w_data_q); // [R9] [R13] [R14]
					default: begin
						// The reserved register and the flags take no stored value from a write.
						ocpe_q <= ocpe_q; // [R6]
					end
				endcase
			end
			irq_q <= |oc_pending; // [R10] [R15]
		end
	end

	// Pad outputs are registered so the pins never see decode glitches.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pad_s_q    <= 8'h00;
			pad_s_oe_q <= 8'h00;
			pad_j_q    <= 8'h00;
			pad_j_oe_q <= 8'h00;
		end else begin
			pad_s_q    <= pad_level(ods_s_q, port_s_data_i); // [R1] [R2]
			pad_s_oe_q <= pad_enable(port_s_dir_i, ods_s_q, port_s_data_i);
			pad_j_q    <= pad_level(ods_j_q, port_j_data_i); // [R1] [R2]
			pad_j_oe_q <= pad_enable(port_j_dir_i, ods_j_q, port_j_data_i);
		end
	end

	// Write channel: address and data are caught in either order, then one response.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= {`PODC_AW{1'b0}};
			w_data_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `PODC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && awready_q) begin
				awready_q <= 1'b0;
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && wready_q) begin
				wready_q <= 1'b0;
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata_i[7:0];
				w_lane_q <= s_axi_wstrb_i[0];
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (wr_sel == `PODC_SEL_NONE) ? `PODC_RESP_DECERR : `PODC_RESP_OKAY;
			end
			if (bvalid_q && s_axi_bready_i) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always @* begin
		rd_resp = `PODC_RESP_OKAY;
		case (rd_sel)
			`PODC_SEL_ODS_S: rd_byte = ods_s_q & `PODC_ODS_S_MASK; // [R4]
			`PODC_SEL_ODS_J: rd_byte = ods_j_q & `PODC_ODS_J_MASK; // [R4]
			`PODC_SEL_RSVD:  rd_byte = `PODC_RSVD_VALUE; // [R6]
			`PODC_SEL_OCPE:  rd_byte = oc_keep(ocpe_q); // [R13] [R14]
			`PODC_SEL_OCIE:  rd_byte = oc_keep(ocie_q); // [R13] [R14]
			`PODC_SEL_OCIF:  rd_byte = oc_keep(ocif_q); // [R11] [R12] [R14]
			default: begin
				rd_byte = 8'h00;
				rd_resp = `PODC_RESP_DECERR;
			end
		endcase
	end

	// Read channel: one read at a time, answered in the cycle after the address is taken.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `PODC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid_i && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= {24'h000000, rd_byte};
				rresp_q   <= rd_resp;
			end
			if (rvalid_q && s_axi_rready_i) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready_o  = awready_q;
	assign s_axi_wready_o   = wready_q;
	assign s_axi_bvalid_o   = bvalid_q;
	assign s_axi_bresp_o    = bresp_q;
	assign s_axi_arready_o  = arready_q;
	assign s_axi_rvalid_o   = rvalid_q;
	assign s_axi_rdata_o    = rdata_q;
	assign s_axi_rresp_o    = rresp_q;
	assign pad_s_o          = pad_s_q;
	assign pad_s_oe_o       = pad_s_oe_q;
	assign pad_j_o          = pad_j_q;
	assign pad_j_oe_o       = pad_j_oe_q;
	assign oc_detector_en_o = ocpe_q; // [R7] [R8]
	assign oc_irq_o         = irq_q; // [R15]

endmodule // podc_port_ctl

`default_nettype wire

// ---- tb/podc_chk_chk.sv ----
// Concurrent checks on the ports of the port drive and over-current block.
`timescale 1ns/1ps
`default_nettype none
module podc_chk (
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [7:0]  port_s_data_i,
	input wire logic [7:0]  port_s_dir_i,
	input wire logic [7:0]  pad_s_o,
	input wire logic [7:0]  pad_s_oe_o,
	input wire logic [7:0]  oc_detector_en_o,
	input wire logic        oc_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	AST_WR_ANSWER: assert property (
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write not answered");
	AST_B_BLOCKS: assert property (
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write taken during response");
	AST_RD_ANSWER: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read late");
	AST_RD_UPPER: assert property (
		s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0) else $error("upper read bits set");
	AST_OE_INPUT: assert property (
		(pad_s_oe_o & ~$past(port_s_dir_i)) == 8'h00) else $error("input pin driven");
	AST_OE_LEVEL: assert property (
		(pad_s_oe_o & $past(port_s_data_i)) == (pad_s_oe_o & pad_s_o)) else $error("drive level wrong");
	AST_OC_UNUSED: assert property (
		(oc_detector_en_o & 8'h8a) == 8'h00) else $error("unused detector enabled");
	AST_IRQ_CAUSE: assert property (
		$rose(oc_irq_o) |-> $past(oc_detector_en_o, 2) != 8'h00 || $past(s_axi_bvalid_o))
		else $error("request without detector or enable write");
	cover property ($rose(oc_irq_o));
	cover property (s_axi_bvalid_o);
	cover property (s_axi_rvalid_o && s_axi_rdata_o != 32'h0);
endmodule // podc_chk
bind podc_port_ctl podc_chk u_chk (.*);
`default_nettype wire

// ---- tb/podc_oc_far.sv ----
// Over-current detector model standing at the port pins and the switched supply.
`timescale 1ns/1ps
`default_nettype none
module podc_oc_far (
	input  wire logic [7:0] en_i,
	input  wire logic [7:0] fault_i,
	output logic      [7:0] det_o
);
	// A detector that is switched off senses nothing, whatever the load does.
	assign det_o = fault_i & en_i;
endmodule // podc_oc_far
`default_nettype wire

// ---- tb/tb_port_open_drain_and_overcurrent_ctl.sv ----
// Self-checking bench of the port drive and over-current block against a register model.
`timescale 1ns/1ps
`default_nettype none
`include "podc_defines.vh"
module tb_port_open_drain_and_overcurrent_ctl;
	logic        clk_i = 0, arst_n_i = 0, awv = 0, wv = 0, arv = 0;
	logic [15:0] awa = 0, ara = 0, ad [0:5];
	logic [3:0]  ws = 4'hf;
	logic [7:0]  wd = 0, sd = 0, sdir = 0, jd = 0, jdir = 0, flt = 0;
	wire         awr, wrd, bv, arr, rv, irq;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	wire  [7:0]  ps, pso, pj, pjo, den, det;
	integer      failures = 0, checks = 0, seed = 32'ha608a405, m [0:5], i, k, n;
	initial forever #4 clk_i = ~clk_i;
	podc_port_ctl DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i({24'h0, wd}), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
		.s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .port_s_data_i(sd),
		.port_s_dir_i(sdir), .port_j_data_i(jd), .port_j_dir_i(jdir), .pad_s_o(ps), .pad_s_oe_o(pso),
		.pad_j_o(pj), .pad_j_oe_o(pjo), .oc_detect_i(det), .oc_detector_en_o(den), .oc_irq_o(irq));
	podc_oc_far FAR (.en_i(den), .fault_i(flt), .det_o(det));
	task cmp(input string nm, input [31:0] e, input [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		if (failures == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task tmo;
		if (n == 40) begin
			failures++;
			end_sim;
		end
	endtask
	// Both ready inputs stay high, so a response is taken at the first edge it shows.
	task axi_wr(input [15:0] a, input [7:0] d, input [1:0] e);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			if (bv) break;
		end
		tmo;
		cmp("bresp", e, br);
	endtask
	task axi_rd(input [15:0] a, input [7:0] e, input [1:0] r);
		ara <= a;
		arv <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (arr) arv <= 0;
			if (rv) break;
		end
		tmo;
		cmp("rdata", {24'h0, e}, rdat);
		cmp("rresp", r, rr);
	endtask
	task mdl_wr(input integer j, input [7:0] d);
		axi_wr(ad[j], d, `PODC_RESP_OKAY);
		case (j)
			0, 1: m[j] = d;
			3, 4: m[j] = d & 8'h75;
			5: m[j] = m[j] & ~d;
			default: ; // The reserved place keeps nothing.
		endcase
	endtask
	initial begin
		ad = '{{`PODC_IDX_ODS_S, 2'b00}, {`PODC_IDX_ODS_J, 2'b00}, {`PODC_IDX_RSVD, 2'b00},
			{`PODC_IDX_OCPE, 2'b00}, {`PODC_IDX_OCIE, 2'b00}, {`PODC_IDX_OCIF, 2'b00}};
		for (k = 0; k < 6; k++) m[k] = 0;
		repeat (12) @(posedge clk_i);
		arst_n_i <= 1;
		for (k = 0; k < 6; k++) axi_rd(ad[k], 8'h00, `PODC_RESP_OKAY);
		axi_rd(16'h0ffc, 8'h00, `PODC_RESP_DECERR);
		axi_wr(16'h0ffc, 8'h5a, `PODC_RESP_DECERR);
		// A write without the low byte lane is answered but stores nothing.
		ws <= 4'he;
		axi_wr(ad[0], 8'ha5, `PODC_RESP_OKAY);
		axi_rd(ad[0], m[0][7:0], `PODC_RESP_OKAY);
		ws <= 4'hf;
		for (i = 0; i < 24; i++) begin
			mdl_wr(i % 6, 8'($random(seed)));
			axi_rd(ad[i % 6], m[i % 6][7:0], `PODC_RESP_OKAY);
			cmp("det_en", m[3], den);
		end
		for (i = 0; i < 30; i++) begin
			mdl_wr(i % 2, 8'($random(seed)));
			sd <= 8'($random(seed));
			sdir <= 8'($random(seed));
			jd <= 8'($random(seed));
			jdir <= 8'($random(seed));
			@(posedge clk_i);
			@(negedge clk_i);
			cmp("pad_s", sd & ~m[0][7:0], ps);
			cmp("oe_s", sdir & (~m[0][7:0] | ~sd), pso);
			cmp("pad_j", jd & ~m[1][7:0], pj);
			cmp("oe_j", jdir & (~m[1][7:0] | ~jd), pjo);
			@(posedge clk_i);
		end
		for (i = 0; i < 10; i++) begin
			mdl_wr(3, 8'($random(seed)));
			mdl_wr(4, 8'($random(seed)));
			k = $random(seed);
			flt <= k[7:0];
			repeat (5) @(posedge clk_i);
			@(negedge clk_i);
			m[5] = m[5] | (k & m[3]);
			cmp("irq", |(m[5] & m[4]), irq);
			@(posedge clk_i);
			// A clear while the fault persists must not stick.
			mdl_wr(5, 8'hff);
			m[5] = m[5] | (k & m[3]);
			axi_rd(ad[5], m[5][7:0], `PODC_RESP_OKAY);
			flt <= 8'h00;
			repeat (4) @(posedge clk_i);
			mdl_wr(5, 8'($random(seed)));
			axi_rd(ad[5], m[5][7:0], `PODC_RESP_OKAY);
			@(negedge clk_i);
			cmp("irq", |(m[5] & m[4]), irq);
			@(posedge clk_i);
		end
		end_sim;
	end
endmodule // tb_port_open_drain_and_overcurrent_ctl
`default_nettype wire
